// ===== hw/adc_input_scan_select.sv
// module: input selection register and automatic pin-scan sequencer for the converter
// ****************************************
// Overview of operation
// R1: nonzero scan count means scanning is active
// R2: first conversion uses positive select plus offset
// R3: each completed conversion increments the offset
// R4: scan covers count plus one inputs
// R5: range spans base+offset to base+offset+count
// R6: software keeps scan range within existing channels
// R7: negative select: pins 0-7, two grounds
// R8: positive select codes map pins in order
// R9: software sets sampling time for internal sources
// R10: offset returns to zero after last input
// ****************************************
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_input_scan_select (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic [7:0]               i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic                     i_conv_done,
  output logic      [31:0]              o_rdata,
  output logic      [4:0]               o_positive_input_select,
  output logic      [4:0]               o_negative_input_select,
  output logic                          o_negative_reserved,
  output logic                          o_scan_active
);
  typedef struct packed {
    logic [4:0]  pos_base;
    logic [4:0]  neg_code;
    logic [3:0]  count;
    logic [3:0]  offset;
    logic [3:0]  step;
    logic [31:0] rdata;
  } state_type;

  state_type st;
  state_type next_st;
  adc_scan_pkg::bus_req_type req;
  adc_scan_pkg::mux_sel_type sel;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] pack_select(input state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[adc_scan_pkg::pos_lsb +: adc_scan_pkg::pos_w]       = s.pos_base;
    v[adc_scan_pkg::neg_lsb +: adc_scan_pkg::neg_w]       = s.neg_code;
    v[adc_scan_pkg::count_lsb +: adc_scan_pkg::count_w]   = s.count;
    v[adc_scan_pkg::offset_lsb +: adc_scan_pkg::offset_w] = s.offset;
    return v;
  endfunction

  // status word: live positive input, reserved-negative flag and scan state at fixed bits
  function automatic logic [31:0] pack_status(input state_type s, input adc_scan_pkg::mux_sel_type m);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[adc_scan_pkg::pos_lsb +: adc_scan_pkg::pos_w] = m.positive_input_select;
    v[adc_scan_pkg::status_reserved_bit]            = m.negative_reserved;
    v[adc_scan_pkg::status_active_bit]              = (s.count != adc_scan_pkg::zero_nibble);
    return v;
  endfunction

  adc_scan_mux u_mux (
    .i_pos_base (st.pos_base),
    .i_offset   (st.offset),
    .i_neg_code (st.neg_code),
    .o_sel      (sel)
  );

  // ****************************************
  // next state
  // ****************************************
  // step counts conversions within one scan; conversion done beside a write: write wins,
  // since software then restarts the scan from the new offset
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    if (i_conv_done && (st.count != adc_scan_pkg::zero_nibble)) begin  // R1
      if (st.step == st.count) begin  // R4 R5
        next_st.offset = adc_scan_pkg::zero_nibble;  // R10
        next_st.step   = adc_scan_pkg::zero_nibble;
      end else begin
        next_st.offset = st.offset + 4'h1;  // R3
        next_st.step   = st.step + 4'h1;
      end
    end
    if (req.wr && (req.addr == adc_scan_pkg::addr_input_select)) begin
      next_st.pos_base = req.wdata[adc_scan_pkg::pos_lsb +: adc_scan_pkg::pos_w];
      next_st.neg_code = req.wdata[adc_scan_pkg::neg_lsb +: adc_scan_pkg::neg_w];
      next_st.count    = req.wdata[adc_scan_pkg::count_lsb +: adc_scan_pkg::count_w];
      next_st.offset   = req.wdata[adc_scan_pkg::offset_lsb +: adc_scan_pkg::offset_w];  // R2
      next_st.step     = adc_scan_pkg::zero_nibble;
    end
    if (req.rd) begin
      unique case (req.addr)
        adc_scan_pkg::addr_input_select: next_st.rdata = pack_select(st);
        adc_scan_pkg::addr_scan_status:  next_st.rdata = pack_status(st, sel);  // R1 R7
        default: next_st.rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata                 = st.rdata;
  assign o_positive_input_select = sel.positive_input_select;
  assign o_negative_input_select = sel.negative_input_select;
  assign o_negative_reserved     = sel.negative_reserved;
  assign o_scan_active           = (st.count != adc_scan_pkg::zero_nibble);  // R1

  // ****************************************
  // checks
  // ****************************************
  property p_offset_step;  // R3
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_conv_done && !i_wr && o_scan_active && st.step != st.count)
      |=> (st.offset == $past(st.offset) + 4'h1);
  endproperty
  a_offset_step: assert property (p_offset_step) else $error("offset did not advance");  // R3

  property p_wrap;  // R10
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_conv_done && !i_wr && o_scan_active && st.step == st.count) |=> (st.offset == 4'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("offset not cleared at scan end");  // R10

  property p_idle;  // R1
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_conv_done && !i_wr && !o_scan_active) |=> $stable(st.offset);
  endproperty
  a_idle: assert property (p_idle) else $error("offset moved with scan off");  // R1

  property p_pos_sum;  // R2
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && i_addr == adc_scan_pkg::addr_input_select)
      |=> o_positive_input_select == $past(i_wdata[adc_scan_pkg::pos_lsb +: adc_scan_pkg::pos_w]) +
          {1'b0, $past(i_wdata[adc_scan_pkg::offset_lsb +: adc_scan_pkg::offset_w])};
  endproperty
  a_pos_sum: assert property (p_pos_sum) else $error("positive input not base plus offset");  // R2

  property p_count;  // R4
    @(posedge i_mclk) disable iff (!i_rst_n) st.step <= st.count || st.count == 4'h0;
  endproperty
  a_count: assert property (p_count) else $error("step beyond scan count");  // R4

  property p_neg;  // R7
    @(posedge i_mclk) disable iff (!i_rst_n)
      (o_negative_input_select == adc_scan_pkg::io_ground_input) |-> !o_negative_reserved;
  endproperty
  a_neg: assert property (p_neg) else $error("io ground flagged reserved");  // R7

  property p_read;  // R8
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && i_addr == adc_scan_pkg::addr_input_select && !i_wr && !i_conv_done)
      |=> o_rdata[4:0] == $past(st.pos_base);
  endproperty
  a_read: assert property (p_read) else $error("readback of positive select wrong");  // R8

  property p_range;  // R5
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && i_addr == adc_scan_pkg::addr_input_select) |=> st.step == 4'h0;
  endproperty
  a_range: assert property (p_range) else $error("scan not restarted by write");  // R5

  // status flags must mirror the live outputs seen at the read strobe
  property p_status_bits;  // R1
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && i_addr == adc_scan_pkg::addr_scan_status)
      |=> (o_rdata[adc_scan_pkg::status_active_bit] == $past(o_scan_active)) &&
          (o_rdata[adc_scan_pkg::status_reserved_bit] == $past(o_negative_reserved));
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status flags wrong");  // R1

  // the negative code reaches the mux one cycle after the write
  property p_neg_write;  // R7
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && i_addr == adc_scan_pkg::addr_input_select)
      |=> o_negative_input_select == $past(i_wdata[adc_scan_pkg::neg_lsb +: adc_scan_pkg::neg_w]);
  endproperty
  a_neg_write: assert property (p_neg_write) else $error("negative code not taken from write");  // R7

  // codes between the last pin and internal ground are reserved
  property p_reserved_band;  // R7
    @(posedge i_mclk) disable iff (!i_rst_n)
      (o_negative_input_select > adc_scan_pkg::neg_pin_last &&
       o_negative_input_select < adc_scan_pkg::neg_int_ground) |-> o_negative_reserved;
  endproperty
  a_reserved_band: assert property (p_reserved_band) else $error("reserved code not flagged");  // R7

  // inside a scan the mux walks to the next positive input; an offset wrap at four bits is left out
  property p_scan_walk;  // R5
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_conv_done && !i_wr && o_scan_active && st.step != st.count && !(&st.offset))
      |=> o_positive_input_select == $past(o_positive_input_select) + 5'h01;
  endproperty
  a_scan_walk: assert property (p_scan_walk) else $error("positive input did not advance");  // R5

  // the count field lands as written, so the scan length follows it
  property p_count_write;  // R4
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && i_addr == adc_scan_pkg::addr_input_select)
      |=> st.count == $past(i_wdata[adc_scan_pkg::count_lsb +: adc_scan_pkg::count_w]);
  endproperty
  a_count_write: assert property (p_count_write) else $error("scan count not taken from write");  // R4

  // after the last input the mux is back at the base positive input
  property p_last_input;  // R10
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_conv_done && !i_wr && o_scan_active && st.step == st.count)
      |=> o_positive_input_select == st.pos_base;
  endproperty
  a_last_input: assert property (p_last_input) else $error("scan did not return to base");  // R10
endmodule // adc_input_scan_select
`default_nettype wire

// ===== hw/adc_scan_pkg.sv
// package: register map, field layout and types for the adc input scan select block
package adc_scan_pkg;
  localparam logic [7:0] addr_input_select = 8'h00;  // the input selection register
  localparam logic [7:0] addr_scan_status  = 8'h04;  // current positive input and scan state
  localparam int pos_lsb    = 0;
  localparam int pos_w      = 5;
  localparam int neg_lsb    = 8;
  localparam int neg_w      = 5;
  localparam int count_lsb  = 16;
  localparam int count_w    = 4;
  localparam int offset_lsb = 20;
  localparam int offset_w   = 4;
  localparam logic [4:0] neg_pin_last   = 5'h07;
  localparam logic [4:0] neg_int_ground = 5'h18;
  localparam logic [4:0] io_ground_input = 5'h19;
  localparam logic [31:0] select_reset  = 32'h0000_0000;
  localparam logic [3:0] zero_nibble    = 4'h0;
  localparam int status_reserved_bit    = 9;   // status word: reserved negative code selected
  localparam int status_active_bit      = 10;  // status word: scan running

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic [4:0] positive_input_select;
    logic [4:0] negative_input_select;
    logic       negative_reserved;
  } mux_sel_type;
endpackage : adc_scan_pkg

// ===== hw/adc_scan_mux.sv
// module: combinational route from the select fields to the analog mux codes
`timescale 1ns/1ps
`default_nettype none
module adc_scan_mux (
  input  wire logic [4:0]               i_pos_base,
  input  wire logic [3:0]               i_offset,
  input  wire logic [4:0]               i_neg_code,
  output var adc_scan_pkg::mux_sel_type o_sel
);
  // ****************************************
  // mux selection
  // ****************************************
  // positive input is base plus offset; sum wraps at five bits, software keeps it in range
  always_comb begin
    o_sel.positive_input_select = i_pos_base + {1'b0, i_offset};  // R2 R8
    o_sel.negative_input_select = i_neg_code;                     // R7
    o_sel.negative_reserved     = !((i_neg_code <= adc_scan_pkg::neg_pin_last) ||
                                    (i_neg_code == adc_scan_pkg::neg_int_ground) ||
                                    (i_neg_code == adc_scan_pkg::io_ground_input));  // R7
  end
endmodule // adc_scan_mux
`default_nettype wire

// ===== verif/conv_core_model.sv
// partner: conversion core model that pulses done a chosen number of cycles after a start
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  input  wire logic       i_mclk,
  input  wire logic       i_start,
  input  wire logic [3:0] i_delay,
  output logic            o_done
);
  int wait_left = -1;
  // done is one cycle wide; a delay of zero answers promptly, larger ones stall the scan
  assign o_done = (wait_left == 0);
  // countdown idles at -1 between conversions so no stray done appears
  always @(posedge i_mclk) begin
    if (i_start) wait_left <= 32'(i_delay);
    else if (wait_left >= 0) wait_left <= wait_left - 1;
  end
endmodule // conv_core_model
`default_nettype wire

// ===== verif/adc_input_scan_select_bench.sv
// bench: register, negative select and scan sequence checks against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module adc_input_scan_select_bench;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, start = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
  logic [4:0]  o_pos, o_neg;
  logic        o_res, o_act, done;
  logic [3:0]  dly = 4'h0;
  int          miscompares = 0, check_count = 0, base = 0, neg = 0, cnt = 0, off = 0, step = 0;

  adc_input_scan_select adc_input_scan_select_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_conv_done(done), .o_rdata(o_rdata),
    .o_positive_input_select(o_pos), .o_negative_input_select(o_neg), .o_negative_reserved(o_res),
    .o_scan_active(o_act));
  conv_core_model conv_core_model_i (.i_mclk(i_mclk), .i_start(start), .i_delay(dly), .o_done(done));

  // ****************
  // bus and compare tasks
  // ****************
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so look there
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk("read data", exp, o_rdata);
    @(posedge i_mclk);
  endtask
  function automatic logic [31:0] regv();
    return 32'(base) | 32'(neg) << 8 | 32'(cnt) << 16 | 32'(off) << 20;
  endfunction
  // compare mux outputs, then read back both registers
  task automatic mchk();
    logic [31:0] rsv;
    logic [31:0] act;
    rsv = 32'(!(neg <= 7 || neg == 24 || neg == 25));
    act = 32'(cnt != 0);
    #1;
    chk("positive select", 32'((base + off) % 32), 32'(o_pos));
    chk("scan active", act, 32'(o_act));
    chk("negative select", 32'(neg), 32'(o_neg));
    chk("negative reserved", rsv, 32'(o_res));
    @(posedge i_mclk);
    rd(8'h00, regv());
    rd(8'h04, 32'((base + off) % 32) | rsv << 9 | act << 10);
  endtask
  // one conversion; the model steps only while a scan is active
  task automatic conv(logic [3:0] d);
    int n = 0;
    dly <= d;
    start <= 1'b1;
    @(posedge i_mclk);
    start <= 1'b0;
    while (n < 40) begin
      #1;
      if (done === 1'b1) break;
      @(posedge i_mclk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      results();
    end
    if (cnt != 0 && step == cnt) begin
      off = 0;
      step = 0;
    end else if (cnt != 0) begin
      off++;
      step++;
    end
    @(posedge i_mclk);
    mchk();
  endtask

  // ****************
  // clock and main sequence
  // ****************
  initial forever #10 i_mclk = ~i_mclk;
  initial begin
    void'($urandom(32'ha65b25eb));
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0000);
    $display("test reset done");
    for (neg = 0; neg < 32; neg++) begin
      wr(8'h00, 32'(neg) << 8);
      mchk();
    end
    neg = 0;
    wr(8'h00, 32'h0000_0003);
    base = 3;
    conv(4'h2);
    $display("test negative done");
    // scan range kept inside the first twenty-two channels, as software must
    // only pin codes are scanned, so no sampling time set-up for internal sources is due
    repeat (6) begin
      base = $urandom % 8;
      cnt = 1 + $urandom % 7;
      off = $urandom % (cnt + 1);
      neg = $urandom % 32;
      step = 0;
      wr(8'h00, regv());
      mchk();
      repeat (cnt + 3) conv(4'($urandom % 4));
    end
    $display("test scan done");
    // conversion done in the cycle of a write: the write wins and restarts the scan
    base = 4;
    cnt = 2;
    off = 1;
    neg = 25;
    step = 0;
    dly <= 4'h0;
    start <= 1'b1;
    @(posedge i_mclk);
    start <= 1'b0;
    wr(8'h00, regv());
    mchk();
    $display("test overlap done");
    results();
  end
endmodule // adc_input_scan_select_bench
`default_nettype wire
